// *** tmh_timer.sv ***
// split 16-bit timer: one half datapath and the wishbone top
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "tmh_map.svh"

module tmh_half #(
  parameter int CW = 16,
  parameter int PW = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic split,
  input wire logic en,
  input wire logic stall,
  input wire logic halt,
  input wire logic [1:0] mode_field,
  input wire logic cap_mode,
  input wire logic alt_sel,
  input wire logic [1:0] evt,
  input wire logic [CW-1:0] ilr,
  input wire logic [CW-1:0] mat,
  input wire logic [PW-1:0] psr,
  input wire logic ilr_wr,
  input wire logic pin,
  output logic [CW-1:0] count_rd,
  output logic pwm_lvl,
  output logic pwm_act,
  output logic timeout_ev,
  output logic match_ev,
  output logic capture_ev,
  output logic en_clr
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] cap;
  logic [PW-1:0] pre;
  logic s1, s2, s3;
  tmh_pkg::tmh_mode_t mode;
  wire [CW-1:0] dec = CW'(cnt - 1'b1);
  wire cnt_zero = (cnt == '0);
  wire run = split & en & ~(stall & halt);
  wire rise = s2 & ~s3;
  wire fall = ~s2 & s3;
  // reserved event code counts nothing
  wire pin_edge = (evt == `TMH_EVT_RISE) ? rise :
                  (evt == `TMH_EVT_FALL) ? fall :
                  (evt == `TMH_EVT_BOTH) ? (rise | fall) : 1'b0;
  wire is_per = (mode_field == `TMH_MR_PERIODIC);

  assign mode = alt_sel ? ((!cap_mode && is_per) ? tmh_pkg::TMH_PWM : tmh_pkg::TMH_OFF) :
                (mode_field == `TMH_MR_ONESHOT) ? tmh_pkg::TMH_ONESHOT :
                is_per ? tmh_pkg::TMH_PERIODIC :
                (mode_field == `TMH_MR_CAPTURE) ? (cap_mode ? tmh_pkg::TMH_ETIME : tmh_pkg::TMH_ECOUNT) :
                tmh_pkg::TMH_OFF;
  assign count_rd = (mode == tmh_pkg::TMH_ETIME) ? cap : cnt;
  assign pwm_act = split & (mode == tmh_pkg::TMH_PWM);

  // only s2 and s3 feed the edge logic; s1 is the metastable stage
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= `TMH_ILR_RST;
      cap <= `TMH_ILR_RST;
      pre <= `TMH_PSR_RST;
      pwm_lvl <= 1'b0;
      timeout_ev <= 1'b0;
      match_ev <= 1'b0;
      capture_ev <= 1'b0;
      en_clr <= 1'b0;
    end else begin
      timeout_ev <= 1'b0;
      match_ev <= 1'b0;
      capture_ev <= 1'b0;
      en_clr <= 1'b0;
      if (ilr_wr) begin
        cnt <= ilr;
        pre <= psr;
      end else if (run) begin
        unique case (mode)
          tmh_pkg::TMH_OFF: begin
          end
          tmh_pkg::TMH_ONESHOT, tmh_pkg::TMH_PERIODIC: begin
            // prescaler as low bits gives a 24-bit range
            if (pre != '0) begin
              pre <= PW'(pre - 1'b1);
            end else if (cnt_zero) begin
              cnt <= ilr;
              pre <= psr;
              timeout_ev <= 1'b1;
              en_clr <= (mode == tmh_pkg::TMH_ONESHOT);
            end else begin
              cnt <= dec;
              pre <= psr;
            end
          end
          tmh_pkg::TMH_ECOUNT: begin
            if (pin_edge) begin
              if (dec == mat) begin
                cnt <= ilr;
                match_ev <= 1'b1;
                en_clr <= 1'b1;
              end else begin
                cnt <= dec;
              end
            end
          end
          tmh_pkg::TMH_ETIME: begin
            cnt <= cnt_zero ? ilr : dec;
            if (pin_edge) begin
              cap <= cnt;
              capture_ev <= 1'b1;
            end
          end
          tmh_pkg::TMH_PWM: begin
            cnt <= cnt_zero ? ilr : dec;
            if (cnt == ilr) begin
              pwm_lvl <= 1'b1;
            end else if (cnt == mat) begin
              pwm_lvl <= 1'b0;
            end
          end
        endcase
      end
    end
  end
endmodule // tmh_half

module tmh_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic debug_halt,
  input wire logic [1:0] ccp_in,
  output logic [1:0] ccp_out,
  output logic [1:0] ccp_oe_n,
  output logic irq
);
  logic [2:0] cfg;
  logic [15:0] ctl;
  logic [15:0] imask;
  logic [15:0] raw;
  logic [3:0] mode_r [2];
  logic [15:0] ilr [2];
  logic [15:0] mat [2];
  logic [7:0] psr [2];
  logic [1:0] ilr_wr;
  wire [15:0] cnt_rd [2];
  wire [1:0] pwm_lvl, pwm_act, to_ev, m_ev, c_ev, en_clr;

  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = acc & wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wbits = wb_dat_i & wmask;
  wire split = (cfg == `TMH_CFG_SPLIT);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m, input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  wire [31:0] cfg_w = merge({29'h0, cfg}, wmask, wb_dat_i);
  wire [31:0] ctl_w = merge({16'h0, ctl}, wmask, wb_dat_i);
  wire [31:0] mask_w = merge({16'h0, imask}, wmask, wb_dat_i);
  wire wr_cfg = wr & (wb_adr_i == `TMH_OFS_CFG);
  wire wr_ctl = wr & (wb_adr_i == `TMH_OFS_CTL);
  wire wr_mask = wr & (wb_adr_i == `TMH_OFS_MASK);
  wire wr_clr = wr & (wb_adr_i == `TMH_OFS_CLR);
  wire [15:0] clr_bits = wr_clr ? wbits[15:0] : 16'h0000;
  wire [15:0] mis = raw & imask;

  // hardware sets win over a clear in the same cycle
  wire [15:0] set_bits = {5'h00, c_ev[1], m_ev[1], to_ev[1], 5'h00, c_ev[0], m_ev[0], to_ev[0]};
  wire [15:0] next_raw = (raw & ~clr_bits) | set_bits;

  // a software write to control overrides a same-cycle hardware disable
  wire [15:0] en_clr_bits = {7'h00, en_clr[1], 7'h00, en_clr[0]};
  wire [15:0] next_ctl = wr_ctl ? ctl_w[15:0] : (ctl & ~en_clr_bits);

  wire [31:0] rd_data =
    (wb_adr_i == `TMH_OFS_CFG) ? {29'h0, cfg} :
    (wb_adr_i == `TMH_OFS_MODE_A) ? {28'h0, mode_r[0]} :
    (wb_adr_i == `TMH_OFS_MODE_B) ? {28'h0, mode_r[1]} :
    (wb_adr_i == `TMH_OFS_CTL) ? {16'h0, ctl} :
    (wb_adr_i == `TMH_OFS_MASK) ? {16'h0, imask} :
    (wb_adr_i == `TMH_OFS_RAW) ? {16'h0, raw} :
    (wb_adr_i == `TMH_OFS_MIS) ? {16'h0, mis} :
    (wb_adr_i == `TMH_OFS_ILR_A) ? {16'h0, ilr[0]} :
    (wb_adr_i == `TMH_OFS_ILR_B) ? {16'h0, ilr[1]} :
    (wb_adr_i == `TMH_OFS_MAT_A) ? {16'h0, mat[0]} :
    (wb_adr_i == `TMH_OFS_MAT_B) ? {16'h0, mat[1]} :
    (wb_adr_i == `TMH_OFS_PSR_A) ? {24'h0, psr[0]} :
    (wb_adr_i == `TMH_OFS_PSR_B) ? {24'h0, psr[1]} :
    (wb_adr_i == `TMH_OFS_CNT_A) ? {16'h0, cnt_rd[0]} :
    (wb_adr_i == `TMH_OFS_CNT_B) ? {16'h0, cnt_rd[1]} : 32'h0000_0000;

  // every access, mapped or not, gets one ack a cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= 3'h0;
      ctl <= 16'h0000;
      imask <= 16'h0000;
      raw <= 16'h0000;
      irq <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg <= cfg_w[2:0];
      end
      if (wr_mask) begin
        imask <= mask_w[15:0];
      end
      ctl <= next_ctl;
      raw <= next_raw;
      irq <= |(next_raw & imask);
    end
  end

  for (genvar h = 0; h < 2; h++) begin : g_half
    localparam logic [7:0] OFS_MODE = (h == 0) ? `TMH_OFS_MODE_A : `TMH_OFS_MODE_B;
    localparam logic [7:0] OFS_ILR = (h == 0) ? `TMH_OFS_ILR_A : `TMH_OFS_ILR_B;
    localparam logic [7:0] OFS_MAT = (h == 0) ? `TMH_OFS_MAT_A : `TMH_OFS_MAT_B;
    localparam logic [7:0] OFS_PSR = (h == 0) ? `TMH_OFS_PSR_A : `TMH_OFS_PSR_B;
    localparam int CB = h * `TMH_HALF_STRIDE;
    wire wr_mode = wr & (wb_adr_i == OFS_MODE);
    wire wr_ilr = wr & (wb_adr_i == OFS_ILR);
    wire wr_mat = wr & (wb_adr_i == OFS_MAT);
    wire wr_psr = wr & (wb_adr_i == OFS_PSR);
    wire [31:0] mode_w = merge({28'h0, mode_r[h]}, wmask, wb_dat_i);
    wire [31:0] ilr_w = merge({16'h0, ilr[h]}, wmask, wb_dat_i);
    wire [31:0] mat_w = merge({16'h0, mat[h]}, wmask, wb_dat_i);
    wire [31:0] psr_w = merge({24'h0, psr[h]}, wmask, wb_dat_i);

    always_ff @(posedge clk) begin
      if (srst) begin
        mode_r[h] <= 4'h0;
        ilr[h] <= `TMH_ILR_RST;
        mat[h] <= 16'h0000;
        psr[h] <= `TMH_PSR_RST;
        ilr_wr[h] <= 1'b0;
        ccp_out[h] <= 1'b0;
        ccp_oe_n[h] <= 1'b1;
      end else begin
        if (wr_mode) begin
          mode_r[h] <= mode_w[3:0];
        end
        if (wr_ilr) begin
          ilr[h] <= ilr_w[15:0];
        end
        if (wr_mat) begin
          mat[h] <= mat_w[15:0];
        end
        if (wr_psr) begin
          psr[h] <= psr_w[7:0];
        end
        ilr_wr[h] <= wr_ilr;
        ccp_out[h] <= pwm_act[h] & (pwm_lvl[h] ^ ctl[CB + `TMH_CTL_INV]);
        ccp_oe_n[h] <= ~pwm_act[h];
      end
    end

    tmh_half #(.CW(16), .PW(8)) u_half (
      .clk(clk),
      .srst(srst),
      .split(split),
      .en(ctl[CB + `TMH_CTL_EN]),
      .stall(ctl[CB + `TMH_CTL_STALL]),
      .halt(debug_halt),
      .mode_field(mode_r[h][`TMH_MODE_MR_LO +: 2]),
      .cap_mode(mode_r[h][`TMH_MODE_CMR]),
      .alt_sel(mode_r[h][`TMH_MODE_AMS]),
      .evt(ctl[CB + `TMH_CTL_EVT_LO +: 2]),
      .ilr(ilr[h]),
      .mat(mat[h]),
      .psr(psr[h]),
      .ilr_wr(ilr_wr[h]),
      .pin(ccp_in[h]),
      .count_rd(cnt_rd[h]),
      .pwm_lvl(pwm_lvl[h]),
      .pwm_act(pwm_act[h]),
      .timeout_ev(to_ev[h]),
      .match_ev(m_ev[h]),
      .capture_ev(c_ev[h]),
      .en_clr(en_clr[h])
    );
  end
endmodule // tmh_timer

// *** tmh_map.svh ***
// register offsets, field positions and reset values of the split timer
//
// Function
// - config value 0x4 selects split halves
// - both halves share one parameterised design
// - timer modes: 16-bit count, 8-bit prescale
// - count down, reload after zero on next prescaled tick
// - one-shot stops, clears enable; periodic continues
// - zero sets sticky raw timeout, masked too
// - new interval load taken next cycle
// - debug stall freezes counting while halted
// - prescaler used only in timer modes
// - edge count: capture bit 0, event select
// - each edge decrements; match sets match flag
// - after match reload, disable, ignore edges
// - edge time: capture bit 1, free-run
// - edge latches count, sets capture flag
// - edge time keeps running, reloads at zero
// - pwm: alternate 1, capture 0, mode 2
// - pwm reloads after zero, no flags
// - pwm high at load, low at match
// - invert bit complements pwm output
// - mode 1 one-shot, mode 2 periodic
// - mode 3 capture, bit picks count/time
// - writing one to clear drops flag
`ifndef TMH_MAP_SVH
`define TMH_MAP_SVH
`define TMH_OFS_CFG 8'h00
`define TMH_OFS_MODE_A 8'h04
`define TMH_OFS_MODE_B 8'h08
`define TMH_OFS_CTL 8'h0c
`define TMH_OFS_MASK 8'h10
`define TMH_OFS_RAW 8'h14
`define TMH_OFS_MIS 8'h18
`define TMH_OFS_CLR 8'h1c
`define TMH_OFS_ILR_A 8'h20
`define TMH_OFS_ILR_B 8'h24
`define TMH_OFS_MAT_A 8'h28
`define TMH_OFS_MAT_B 8'h2c
`define TMH_OFS_PSR_A 8'h30
`define TMH_OFS_PSR_B 8'h34
`define TMH_OFS_CNT_A 8'h38
`define TMH_OFS_CNT_B 8'h3c
`define TMH_CFG_SPLIT 3'h4
`define TMH_MR_ONESHOT 2'h1
`define TMH_MR_PERIODIC 2'h2
`define TMH_MR_CAPTURE 2'h3
`define TMH_EVT_RISE 2'h0
`define TMH_EVT_FALL 2'h1
`define TMH_EVT_BOTH 2'h3
`define TMH_MODE_MR_LO 0
`define TMH_MODE_CMR 2
`define TMH_MODE_AMS 3
`define TMH_HALF_STRIDE 8
`define TMH_CTL_EN 0
`define TMH_CTL_STALL 1
`define TMH_CTL_EVT_LO 2
`define TMH_CTL_INV 6
`define TMH_IRQ_TO 0
`define TMH_IRQ_MATCH 1
`define TMH_IRQ_CAP 2
`define TMH_ILR_RST 16'hffff
`define TMH_PSR_RST 8'h00
`endif

// *** tmh_pkg.sv ***
// types shared by the split timer
package tmh_pkg;
  typedef enum logic [2:0] {
    TMH_OFF,
    TMH_ONESHOT,
    TMH_PERIODIC,
    TMH_ECOUNT,
    TMH_ETIME,
    TMH_PWM
  } tmh_mode_t;
endpackage

// *** tmh_timer_props.sv ***
// concurrent checks on the split timer ports
`timescale 1ns/1ps
module tmh_timer_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic debug_halt,
  input wire logic [1:0] ccp_in,
  input wire logic [1:0] ccp_out,
  input wire logic [1:0] ccp_oe_n,
  input wire logic irq
);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = take && wb_we_i;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_take;
    take;
  endsequence
  sequence s_read(a);
    take && !wb_we_i && wb_adr_i == a;
  endsequence
  chk_ack_latency: assert property (s_take |=> wb_ack_o) else $error("late ack");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_held: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("stray ack");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  chk_unmapped_zero: assert property (s_read(8'h40) |=> wb_dat_o == 32'h0) else $error("unmapped data");
  chk_clear_reads: assert property (s_read(8'h1c) |=> wb_dat_o == 32'h0) else $error("clear reg data");
  chk_reset_state: assert property ($fell(srst) |-> ccp_oe_n == 2'h3 && ccp_out == 2'h0 && !irq)
    else $error("outputs after reset");
  chk_irq_sticky: assert property ($fell(irq) && !$past(srst) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("irq dropped without write");
  chk_oe_cause: assert property ($changed(ccp_oe_n) && !$past(srst) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("enable moved without write");
  chk_out_idle: assert property ((ccp_oe_n & $past(ccp_oe_n) & $past(ccp_oe_n, 2) & ccp_out) == 2'h0)
    else $error("pin driven high outside pwm");
endmodule // tmh_timer_props
bind tmh_timer tmh_timer_props u_props (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_sel_i, .wb_dat_o, .wb_ack_o, .debug_halt, .ccp_in, .ccp_out, .ccp_oe_n, .irq);

// *** tmh_pin_model.sv ***
// far-side signal source toggling a capture pin
`timescale 1ns/1ps
module tmh_pin_model (
  input wire logic clk,
  input wire logic kick,
  input wire logic which,
  input wire logic [7:0] edges,
  output logic [1:0] pin,
  output logic busy
);
  logic [7:0] left;
  logic [3:0] hold;
  initial begin
    pin = 2'h0;
    busy = 1'b0;
    left = 8'h0;
    hold = 4'h0;
  end
  // random hold keeps the source both prompt and slow
  always @(posedge clk) begin
    if (kick) begin
      left <= edges;
      busy <= 1'b1;
      hold <= 4'h4;
    end else if (busy) begin
      if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end else if (left == 8'h0) begin
        busy <= 1'b0;
      end else begin
        pin[which] <= ~pin[which];
        left <= left - 8'h1;
        hold <= 4'(2 + $urandom % 3);
      end
    end
  end
endmodule // tmh_pin_model

// *** tmh_timer_test.sv ***
// self-checking bench for the split timer
`timescale 1ns/1ps
module tmh_timer_test;
  logic clk, srst, cyc, stb, we, halt, kick, which, ack, irq, busy;
  logic [7:0] adr, nedg;
  logic [31:0] dat, rdat, q, v, ld, ps, hi;
  logic [3:0] sel;
  logic [1:0] cout, oe_n, pin, capture_compare_pin, e;
  int mismatches, check_count, n;
  // device output wins wherever its enable is low
  assign capture_compare_pin = (oe_n & pin) | (~oe_n & cout);
  tmh_timer dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .debug_halt(halt), .ccp_in(capture_compare_pin),
    .ccp_out(cout), .ccp_oe_n(oe_n), .irq(irq));
  tmh_pin_model far (.clk(clk), .kick(kick), .which(which), .edges(nedg), .pin(pin), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 99);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 99) chk(0, 1, "no ack");
  endtask
  task wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task toggle(input logic w, input logic [7:0] c);
    @(posedge clk);
    which <= w;
    nedg <= c;
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 999);
    repeat (6) @(posedge clk); // sync and detect latency
  endtask
  // events seen in seven toggles from start level s
  function automatic logic [31:0] evts(input logic [1:0] c, input logic s);
    if (c == 2'h3) return 32'h7;
    return ((c == 2'h0) ^ s) ? 32'h4 : 32'h3;
  endfunction
  initial begin
    {srst, cyc, stb, we, halt, kick, which} = 7'h40;
    {adr, nedg, dat, sel} = {16'h0, 32'h0, 4'hf};
    mismatches = 0;
    check_count = 0;
    void'($urandom(32'h8512));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    bus(0, 8'h20, 0); chk(q, 32'hffff, "load reset");
    bus(0, 8'h38, 0); chk(q, 32'hffff, "count reset");
    bus(0, 8'h40, 0); chk(q, 0, "unmapped");
    $display("test reset done");
    ld = 32'h10 + $urandom % 16;
    ps = $urandom % 4;
    bus(1, 8'h04, 32'h1);
    bus(1, 8'h30, ps);
    bus(1, 8'h20, ld);
    bus(1, 8'h10, 32'h1);
    bus(1, 8'h0c, 32'h1);
    // enabled but not split yet: the half must hold its load
    bus(0, 8'h38, 0); chk(q, ld, "idle unless split");
    bus(1, 8'h00, 32'h4);
    wait_irq;
    chk(n >= (ld + 1) * (ps + 1) - 4 && n <= (ld + 1) * (ps + 1) + 4, 1, "period");
    bus(0, 8'h0c, 0); chk(q, 0, "oneshot stop");
    bus(0, 8'h14, 0); chk(q, 1, "raw timeout");
    bus(0, 8'h18, 0); chk(q, 1, "masked timeout");
    bus(1, 8'h1c, 1); bus(0, 8'h18, 0); chk(q, 0, "clear");
    bus(0, 8'h1c, 0); chk(q, 0, "clear reads zero");
    bus(1, 8'h04, 32'h2);
    bus(1, 8'h0c, 32'h1);
    wait_irq;
    bus(1, 8'h1c, 1);
    wait_irq; chk(irq, 1, "periodic again");
    bus(0, 8'h0c, 0); chk(q, 1, "periodic runs");
    bus(1, 8'h20, 32'h800);
    bus(0, 8'h38, 0); chk(q <= 32'h800 && q >= 32'h7f0, 1, "new load");
    bus(1, 8'h0c, 32'h3);
    halt <= 1'b1;
    bus(0, 8'h38, 0);
    v = q;
    bus(0, 8'h38, 0); chk(q, v, "stalled");
    halt <= 1'b0;
    repeat (8) @(posedge clk);
    bus(0, 8'h38, 0); chk(q < v, 1, "resumed");
    bus(1, 8'h0c, 0);
    bus(1, 8'h1c, 32'h707);
    $display("test timer done");
    bus(1, 8'h08, 32'h3);
    for (int i = 0; i < 3; i++) begin
      e = (i == 2) ? 2'h3 : 2'(i);
      v = evts(e, pin[1]);
      bus(1, 8'h0c, 32'(e) << 10);
      bus(1, 8'h24, 32'h40);
      bus(1, 8'h2c, 32'h40 - v - 1);
      bus(1, 8'h0c, (32'(e) << 10) | 32'h100);
      toggle(1, 8'h7);
      bus(0, 8'h3c, 0); chk(q, 32'h40 - v, "edges counted");
      bus(0, 8'h14, 0); chk(q & 32'h200, 0, "early match");
    end
    bus(1, 8'h0c, 32'hc00);
    bus(1, 8'h24, 32'ha);
    bus(1, 8'h2c, 32'h6);
    bus(1, 8'h0c, 32'hd00);
    toggle(1, 8'h6);
    bus(0, 8'h14, 0); chk(q & 32'h200, 32'h200, "match flag");
    bus(0, 8'h0c, 0); chk(q & 32'h100, 0, "count stop");
    bus(0, 8'h3c, 0); chk(q, 32'ha, "reload, rest ignored");
    $display("test edge count done");
    bus(1, 8'h04, 32'h7);
    bus(1, 8'h0c, 32'h1);
    toggle(0, 8'h2);
    bus(0, 8'h14, 0); chk(q & 32'h4, 32'h4, "capture flag");
    bus(0, 8'h38, 0);
    v = q;
    repeat (20) @(posedge clk);
    bus(0, 8'h38, 0); chk(q, v, "capture held");
    toggle(0, 8'h2);
    bus(0, 8'h38, 0); chk(q < v, 1, "still running");
    bus(1, 8'h0c, 0);
    $display("test edge time done");
    bus(1, 8'h04, 32'ha);
    bus(1, 8'h20, 32'h9);
    bus(1, 8'h28, 32'h3);
    bus(1, 8'h1c, 32'h707);
    for (int inv = 0; inv < 2; inv++) begin
      bus(1, 8'h0c, inv ? 32'h41 : 32'h1);
      repeat (20) @(posedge clk);
      hi = 0;
      repeat (20) begin
        @(posedge clk);
        hi = hi + cout[0];
      end
      chk(hi, inv ? 32'd8 : 32'd12, "pwm duty");
    end
    chk(oe_n[0], 0, "pwm drives");
    bus(0, 8'h14, 0); chk(q & 32'h7, 0, "pwm flags");
    $display("test pwm done");
    // reset in mid pwm: the pin must be released at once
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(oe_n, 2'h3, "reset frees pin");
    chk(cout, 2'h0, "reset drops pwm");
    bus(0, 8'h20, 0); chk(q, 32'hffff, "load after reset");
    $display("test reset again done");
    final_report;
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("MISMATCH %0t watchdog", $time);
    final_report;
  end
endmodule // tmh_timer_test
